// file: nlcm_noload_compute_mode.sv
// Purpose: Per-phase no-load flags and compute-mode register behind an
//          Avalon-MM slave with waitrequest.
// Assumes: Detector levels are synchronous to clk_in; 32-bit data bus.
// Notes:   Every access takes one wait cycle; unmapped reads return zero.
//
// The Avalon-MM slave port was chosen for this implementation.
`include "nlcm_regs.svh"

// Function
// - Bits 0..2 show per-phase no-load from total active and reactive power.
// - Setting a total flag also sets the total summary status bit.
// - Without reactive energy, total no-load uses total active power alone.
// - Bits 3..5 show fundamental no-load flags, setting fundamental summary bit.
// - Without fundamental measurement, fundamental flags stay zero.
// - Bits 6..8 show apparent no-load flags, setting apparent summary bit.
// - Status bits 15..9 read zero; all flags reset to zero.
// - Mode bits 0..2 pick phases for pulse output one; reset to one.
// - Mode bits 3..5 pick phases for pulse output two; reset to one.
// - Mode bits 6..8 pick phases for pulse output three; reset to one.
// - All three select bits set means the output uses the phase sum.
// - Angle field 00 measures voltage-current, 01 voltage-voltage; reset 00.
// - Angle field 10 measures current-current angles; 11 measures none.
module nlcm_noload_compute_mode
  import nlcm_pkg::*;
#(
  parameter bit HAS_REACTIVE = 1'b1,
  parameter bit HAS_FUNDAMENTAL = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave
  input wire logic [`NLCM_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // No-load detectors
  input wire nlcm_detect_type detect_in,
  // Flags and summary set pulses toward the main status register
  output nlcm_flags_type idle_flags_out,
  output logic total_idle_summary_flag_out,
  output logic fundamental_idle_summary_flag_out,
  output logic apparent_idle_summary_flag_out,
  // Pulse output phase selection
  output nlcm_phase_type pulse_out_one_phase_select_out,
  output nlcm_phase_type pulse_out_two_phase_select_out,
  output nlcm_phase_type pulse_out_three_phase_select_out,
  output logic [2:0] calib_pulse_sum_all_out,
  // Angle measurement
  output nlcm_angle_type angle_measure_select_out,
  output nlcm_angle_en_type angle_enable_out
);

  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [`NLCM_MODE_W-1:0] mode_reg;
  logic [`NLCM_MODE_W-1:0] mode_next;
  logic [2:0] sum_reg;
  logic [2:0] sum_next;
  nlcm_angle_en_type angle_en_reg;
  nlcm_angle_en_type angle_en_next;
  nlcm_angle_type angle_next;

  wire logic [`NLCM_ADDR_W-1:0] status_addr = {`NLCM_STATUS_IDX, 2'b00};
  wire logic [`NLCM_ADDR_W-1:0] mode_addr = {`NLCM_MODE_IDX, 2'b00};
  wire logic hit_status = (avs_address_in == status_addr);
  wire logic hit_mode = (avs_address_in == mode_addr);
  wire logic req = avs_read_in | avs_write_in;
  wire logic read_start = avs_read_in & wait_reg;
  wire logic write_take = avs_write_in & ~wait_reg;
  wire logic mode_write = write_take & hit_mode;

  // Waitrequest drops for exactly one cycle per request.
  assign wait_next = wait_reg ? ~req : 1'b1;

  // Detector conditions per phase.
  nlcm_phase_type total_cond;
  nlcm_phase_type fund_cond;
  assign total_cond = HAS_REACTIVE ?
    (detect_in.total_active & detect_in.total_reactive) :
    detect_in.total_active;
  assign fund_cond = detect_in.fund_active & detect_in.fund_reactive;

  nlcm_phase_type total_flags;
  nlcm_phase_type fund_flags;
  nlcm_phase_type appar_flags;

  nlcm_idle_flags #(
    .ENABLE(1'b1)
  ) u_total_flags (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cond_in(total_cond),
    .flags_out(total_flags),
    .set_pulse_out(total_idle_summary_flag_out)
  );

  nlcm_idle_flags #(
    .ENABLE(HAS_FUNDAMENTAL)
  ) u_fund_flags (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cond_in(fund_cond),
    .flags_out(fund_flags),
    .set_pulse_out(fundamental_idle_summary_flag_out)
  );

  nlcm_idle_flags #(
    .ENABLE(1'b1)
  ) u_appar_flags (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cond_in(detect_in.apparent),
    .flags_out(appar_flags),
    .set_pulse_out(apparent_idle_summary_flag_out)
  );

  wire logic [15:0] status_word = {7'h00, appar_flags, fund_flags,
    total_flags};

  // Bits above the mode field are outside this block and read zero.
  wire logic [31:0] mode_word = {21'h0, mode_reg};
  wire logic [31:0] read_mux = hit_status ? {16'h0000, status_word} :
    (hit_mode ? mode_word : 32'h00000000);
  assign rdata_next = read_start ? read_mux : rdata_reg;

  // status writes ignored
  // Only the mode address is writable; a status write leaves no trace.
  wire logic [7:0] mode_lo = avs_byteenable_in[0] ?
    avs_writedata_in[7:0] : mode_reg[7:0];
  wire logic [2:0] mode_hi = avs_byteenable_in[1] ?
    avs_writedata_in[10:8] : mode_reg[10:8];
  assign mode_next = mode_write ? {mode_hi, mode_lo} : mode_reg;

  assign sum_next = {
    mode_next[`NLCM_SEL3_LSB +: 3] == `NLCM_ALL_PHASES,
    mode_next[`NLCM_SEL2_LSB +: 3] == `NLCM_ALL_PHASES,
    mode_next[`NLCM_SEL1_LSB +: 3] == `NLCM_ALL_PHASES};

  assign angle_next =
    nlcm_angle_type'(mode_next[`NLCM_ANGLE_MSB:`NLCM_ANGLE_LSB]);

  always_comb begin
    angle_en_next = '0;
    unique case (angle_next)
      NLCM_ANG_VOLT_CURR: begin
        angle_en_next.volt_curr = 1'b1;
      end
      NLCM_ANG_VOLT_VOLT: begin
        angle_en_next.volt_volt = 1'b1;
      end
      NLCM_ANG_NONE: begin
        angle_en_next = '0;
      end
      NLCM_ANG_CURR_CURR: begin
        angle_en_next.curr_curr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      mode_reg <= `NLCM_MODE_RST;
      sum_reg <= `NLCM_SUM_RST;
      angle_en_reg <= `NLCM_ANG_EN_RST;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      mode_reg <= mode_next;
      sum_reg <= sum_next;
      angle_en_reg <= angle_en_next;
    end
  end

  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out = rdata_reg;
  assign idle_flags_out = '{apparent: appar_flags,
    fundamental: fund_flags, total: total_flags};
  assign pulse_out_one_phase_select_out = mode_reg[`NLCM_SEL1_LSB +: 3];
  assign pulse_out_two_phase_select_out = mode_reg[`NLCM_SEL2_LSB +: 3];
  assign pulse_out_three_phase_select_out = mode_reg[`NLCM_SEL3_LSB +: 3];
  assign calib_pulse_sum_all_out = sum_reg;
  assign angle_measure_select_out =
    nlcm_angle_type'(mode_reg[`NLCM_ANGLE_MSB:`NLCM_ANGLE_LSB]);
  assign angle_enable_out = angle_en_reg;

  // Checks on the bus handshake and on the register behaviour.
  sequence s_read_req;
    avs_read_in && wait_reg && !avs_write_in;
  endsequence

  sequence s_read_done;
    ##1 !avs_waitrequest_out;
  endsequence

  a_bus_one_wait: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (req && wait_reg) |=> !avs_waitrequest_out ##1 avs_waitrequest_out
  ) else $error("Waitrequest did not drop for exactly one cycle.");

  a_total_flag_read: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_read_req and hit_status) |-> s_read_done
      ##0 (avs_readdata_out[2:0] == $past(total_flags))
  ) else $error("Status read did not return the total flags.");

  a_active_only_total: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (!HAS_REACTIVE && detect_in.total_active == 3'h7)
      |=> (total_flags == 3'h7)
  ) else $error("Total flags ignored active-only no-load.");

  a_fund_summary_set: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (HAS_FUNDAMENTAL && fund_cond[0] && !fund_flags[0])
      |=> fund_flags[0] && fundamental_idle_summary_flag_out
  ) else $error("Fundamental flag rose without its summary set.");

  a_fund_held_zero: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !HAS_FUNDAMENTAL |-> (fund_flags == 3'h0)
      && !fundamental_idle_summary_flag_out
  ) else $error("Fundamental flags set in a variant without them.");

  a_appar_summary_set: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (detect_in.apparent[2] && !appar_flags[2])
      |=> appar_flags[2] && apparent_idle_summary_flag_out
  ) else $error("Apparent flag rose without its summary set.");

  a_status_rsvd_zero: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_read_req and hit_status) |-> s_read_done
      ##0 (avs_readdata_out[31:`NLCM_STATUS_RSVD_LSB] == 23'h0)
  ) else $error("Reserved status bits read nonzero.");

  a_mode_reset_value: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (mode_reg == `NLCM_MODE_RST)
      && (calib_pulse_sum_all_out == 3'h7)
  ) else $error("Compute mode did not reset to all phases selected.");

  a_sel_two_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_write && avs_byteenable_in[0]) |=>
      pulse_out_two_phase_select_out == $past(avs_writedata_in[5:3])
  ) else $error("Pulse two select did not take the written value.");

  a_sel_three_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_write && avs_byteenable_in[1:0] == 2'h3) |=>
      pulse_out_three_phase_select_out == $past(avs_writedata_in[8:6])
  ) else $error("Pulse three select did not take the written value.");

  a_sum_all_match: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    calib_pulse_sum_all_out[0] == (&pulse_out_one_phase_select_out)
  ) else $error("Sum-of-phases indication disagrees with selection.");

  a_angle_volt_modes: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (angle_enable_out.volt_curr == (angle_measure_select_out == 2'h0))
      && (angle_enable_out.volt_volt == (angle_measure_select_out == 2'h1))
  ) else $error("Voltage angle enables disagree with angle field.");

  a_angle_curr_none: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (angle_measure_select_out == 2'h3 |-> angle_enable_out == 3'h0)
      and (angle_enable_out.curr_curr == (angle_measure_select_out == 2'h2))
  ) else $error("Current or disabled angle mode decoded wrongly.");

  a_status_write_ro: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (write_take && hit_status) |=> $stable(mode_reg)
      && (total_flags == $past(total_cond))
  ) else $error("Status write disturbed register state.");

  a_total_flag_follow: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (total_cond != total_flags)
      |=> (total_flags == $past(total_cond))
  ) else $error("Total flags did not follow their detectors.");

  a_total_summary_set: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (total_cond[1] && !total_flags[1])
      |=> total_flags[1] && total_idle_summary_flag_out
  ) else $error("Total flag rose without its summary set.");

  a_fund_flag_follow: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (HAS_FUNDAMENTAL && (fund_cond != fund_flags))
      |=> (fund_flags == $past(fund_cond))
  ) else $error("Fundamental flags did not follow their detectors.");

  a_appar_flag_follow: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (detect_in.apparent != appar_flags)
      |=> (appar_flags == $past(detect_in.apparent))
  ) else $error("Apparent flags did not follow their detectors.");

  a_flags_reset_zero: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in)
      |-> (idle_flags_out == 9'h000)
  ) else $error("No-load flags were not zero out of reset.");

  a_sel_one_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_write && avs_byteenable_in[0])
      |=> (pulse_out_one_phase_select_out == $past(avs_writedata_in[2:0]))
  ) else $error("Pulse one select did not take the written value.");

  a_mode_read_back: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_read_req and hit_mode) |-> s_read_done
      ##0 (avs_readdata_out == {21'h0, $past(mode_reg)})
  ) else $error("Mode read did not return the stored mode bits.");

  a_sum_two_three: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (calib_pulse_sum_all_out[1] == (&pulse_out_two_phase_select_out))
      && (calib_pulse_sum_all_out[2] == (&pulse_out_three_phase_select_out))
  ) else $error("Sum-of-phases indication disagrees for outputs two, three.");

  a_angle_field_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_write && avs_byteenable_in[1])
      |=> (angle_measure_select_out == $past(avs_writedata_in[10:9]))
  ) else $error("Angle field did not take the written value.");

  a_angle_reset_value: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (angle_measure_select_out == NLCM_ANG_VOLT_CURR)
      && angle_enable_out.volt_curr
  ) else $error("Angle mode did not reset to voltage-current.");

endmodule

// file: nlcm_regs.svh
// Purpose: Offsets, field positions and reset values of the no-load flag
//          and compute-mode register pair.
// Assumes: Register indices are word indices; byte address is four times.
// Notes:   Definitions only.
`ifndef NLCM_REGS_SVH
`define NLCM_REGS_SVH

`define NLCM_ADDR_W 18
`define NLCM_STATUS_IDX 16'hE608
`define NLCM_MODE_IDX 16'hE60E

`define NLCM_TOTAL_LSB 0
`define NLCM_FUND_LSB 3
`define NLCM_APPAR_LSB 6
`define NLCM_STATUS_RSVD_LSB 9
`define NLCM_STATUS_RST 16'h0000

`define NLCM_SEL1_LSB 0
`define NLCM_SEL2_LSB 3
`define NLCM_SEL3_LSB 6
`define NLCM_ANGLE_LSB 9
`define NLCM_ANGLE_MSB 10
`define NLCM_MODE_W 11
`define NLCM_MODE_RST 11'h1FF
`define NLCM_ALL_PHASES 3'h7
`define NLCM_SUM_RST 3'h7
`define NLCM_ANG_EN_RST 3'h4

`endif

// file: nlcm_pkg.sv
// Purpose: Types shared by the no-load flag and compute-mode block.
// Assumes: Three phases, ordered A, B, C from bit 0.
// Notes:   Constants live in nlcm_regs.svh.
package nlcm_pkg;

  typedef logic [2:0] nlcm_phase_type;

  // Detector levels from the power monitors, one bit per phase.
  typedef struct packed {
    nlcm_phase_type total_active;
    nlcm_phase_type total_reactive;
    nlcm_phase_type fund_active;
    nlcm_phase_type fund_reactive;
    nlcm_phase_type apparent;
  } nlcm_detect_type;

  typedef struct packed {
    nlcm_phase_type apparent;
    nlcm_phase_type fundamental;
    nlcm_phase_type total;
  } nlcm_flags_type;

  typedef enum logic [1:0] {
    NLCM_ANG_VOLT_CURR = 2'h0,
    NLCM_ANG_VOLT_VOLT = 2'h1,
    NLCM_ANG_NONE = 2'h3,
    NLCM_ANG_CURR_CURR = 2'h2
  } nlcm_angle_type;

  typedef struct packed {
    logic volt_curr;
    logic volt_volt;
    logic curr_curr;
  } nlcm_angle_en_type;

endpackage

// file: nlcm_idle_flags.sv
// Purpose: One group of three per-phase no-load flags with its summary set.
// Assumes: Detector levels are synchronous to clk_in.
// Notes:   A disabled group holds its flags at zero.
module nlcm_idle_flags
  import nlcm_pkg::*;
#(
  parameter bit ENABLE = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Detector condition
  input wire nlcm_phase_type cond_in,
  // Flags and summary set pulse
  output nlcm_phase_type flags_out,
  output logic set_pulse_out
);

  nlcm_phase_type flags_reg;
  nlcm_phase_type flags_next;
  logic set_reg;
  logic set_next;

  assign flags_next = ENABLE ? cond_in : 3'h0;
  assign set_next = |(flags_next & ~flags_reg);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_reg <= 3'h0;
      set_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      set_reg <= set_next;
    end
  end

  assign flags_out = flags_reg;
  assign set_pulse_out = set_reg;

  a_summary_with_flag: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ##1 (set_pulse_out == (|(flags_out & ~$past(flags_out))))
  ) else $error("Summary set pulse does not match a rising phase flag.");

endmodule

// file: nlcm_noload_compute_mode_tb.sv
// Purpose: Self-checking bench for the no-load flag and compute-mode block.
// Assumes: One wait cycle per bus access; detectors sampled every edge.
// Notes:   A second instance without reactive or fundamental sensing runs
//          on the same inputs, so both build variants are seen at once.
`include "nlcm_regs.svh"
module nlcm_noload_compute_mode_tb
  import nlcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    nlcm_detect_type d;
    nlcm_flags_type f;
  } nlcm_det_row_type;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be;
    logic [10:0] m;
  } nlcm_mode_row_type;

  localparam logic [17:0] STAT_A = {`NLCM_STATUS_IDX, 2'h0};
  localparam logic [17:0] MODE_A = {`NLCM_MODE_IDX, 2'h0};

  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [17:0] avs_address_in = 18'h00000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [3:0] avs_byteenable_in = 4'hF;
  nlcm_detect_type detect_in = '0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  nlcm_flags_type idle_flags_out;
  nlcm_flags_type lite_flags;
  logic tot_p;
  logic fund_p;
  logic app_p;
  nlcm_phase_type sel1;
  nlcm_phase_type sel2;
  nlcm_phase_type sel3;
  logic [2:0] sum_all;
  nlcm_angle_type ang;
  nlcm_angle_en_type ang_en;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic [10:0] mode_exp;
  nlcm_flags_type prev;

  nlcm_det_row_type drows [5] = '{
    '{'{3'h7, 3'h0, 3'h0, 3'h7, 3'h0}, 9'h000},
    '{'{3'h5, 3'h7, 3'h3, 3'h1, 3'h1}, 9'h04D},
    '{'{3'h7, 3'h7, 3'h7, 3'h7, 3'h6}, 9'h1BF},
    '{'{3'h2, 3'h3, 3'h4, 3'h6, 3'h0}, 9'h022},
    '{'{3'h0, 3'h0, 3'h0, 3'h0, 3'h0}, 9'h000}};
  nlcm_mode_row_type mrows [7] = '{
    '{32'h00000000, 4'hF, 11'h000}, '{32'hFFFFFA49, 4'hF, 11'h249},
    '{32'h000005FF, 4'hF, 11'h5FF}, '{32'h000007C0, 4'hF, 11'h7C0},
    '{32'h00000000, 4'h1, 11'h700}, '{32'h000002FF, 4'h2, 11'h200},
    '{32'h000001FF, 4'hC, 11'h200}};

  always #2 clk_in = ~clk_in;

  nlcm_noload_compute_mode dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .detect_in(detect_in), .idle_flags_out(idle_flags_out),
    .total_idle_summary_flag_out(tot_p),
    .fundamental_idle_summary_flag_out(fund_p),
    .apparent_idle_summary_flag_out(app_p),
    .pulse_out_one_phase_select_out(sel1),
    .pulse_out_two_phase_select_out(sel2),
    .pulse_out_three_phase_select_out(sel3),
    .calib_pulse_sum_all_out(sum_all),
    .angle_measure_select_out(ang), .angle_enable_out(ang_en));

  nlcm_noload_compute_mode #(.HAS_REACTIVE(1'b0), .HAS_FUNDAMENTAL(1'b0))
  dut_lite_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(),
    .avs_waitrequest_out(), .detect_in(detect_in),
    .idle_flags_out(lite_flags), .total_idle_summary_flag_out(),
    .fundamental_idle_summary_flag_out(),
    .apparent_idle_summary_flag_out(),
    .pulse_out_one_phase_select_out(), .pulse_out_two_phase_select_out(),
    .pulse_out_three_phase_select_out(), .calib_pulse_sum_all_out(),
    .angle_measure_select_out(), .angle_enable_out());

  task automatic summarize();
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Requests hold until the edge that sees waitrequest low, then drop.
  task automatic bus(input logic wr, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int i;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (i == 20) begin
      errors++;
      summarize();
    end
  endtask

  function automatic logic [2:0] ang_exp(input logic [1:0] s);
    case (s)
      2'h0: return 3'h4;
      2'h1: return 3'h2;
      2'h2: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  task automatic check_mode();
    #1;
    chk("select one", sel1, mode_exp[2:0]);
    chk("select two", sel2, mode_exp[5:3]);
    chk("select three", sel3, mode_exp[8:6]);
    chk("sum all", sum_all, {&mode_exp[8:6], &mode_exp[5:3],
        &mode_exp[2:0]});
    chk("angle select", ang, mode_exp[10:9]);
    chk("angle enable", ang_en, ang_exp(mode_exp[10:9]));
    bus(1'b0, MODE_A, 32'h00000000, 4'hF);
    chk("mode readback", rd, {21'h0, mode_exp});
  endtask

  initial begin
    prev = '0;
    mode_exp = 11'h1FF;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk("flags at reset", idle_flags_out, 32'h0);
    check_mode();
    foreach (mrows[k]) begin
      bus(1'b1, MODE_A, mrows[k].data, mrows[k].be);
      mode_exp = mrows[k].m;
      check_mode();
    end
    foreach (drows[k]) begin
      @(posedge clk_in);
      detect_in <= drows[k].d;
      @(posedge clk_in);
      #1;
      chk("idle flags", idle_flags_out, drows[k].f);
      chk("total pulse", tot_p, |(drows[k].f.total & ~prev.total));
      chk("fund pulse", fund_p,
          |(drows[k].f.fundamental & ~prev.fundamental));
      chk("app pulse", app_p, |(drows[k].f.apparent & ~prev.apparent));
      chk("lite flags", lite_flags, {drows[k].d.apparent, 3'h0,
          drows[k].d.total_active});
      bus(1'b0, STAT_A, 32'h00000000, 4'hF);
      chk("status read", rd, {23'h0, drows[k].f});
      chk("pulses drop", {tot_p, fund_p, app_p}, 3'h0);
      prev = drows[k].f;
    end
    // A write to the status place must not disturb the live flags.
    @(posedge clk_in);
    detect_in <= '1;
    bus(1'b1, STAT_A, 32'h00000000, 4'hF);
    bus(1'b0, STAT_A, 32'h00000000, 4'hF);
    chk("status after write", rd, 32'h000001FF);
    bus(1'b1, 18'h00004, 32'h00000000, 4'hF);
    bus(1'b0, 18'h00004, 32'h00000000, 4'hF);
    chk("unmapped read", rd, 32'h0);
    check_mode();
    // Second reset in mid-run brings every field back to its default.
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("flags in reset", idle_flags_out, 32'h0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    mode_exp = 11'h1FF;
    check_mode();
    summarize();
  end
endmodule
